/* hw/cpu_regs_pkg.sv */
// constants for the processor register complement
// assumes one word-time clock and a synchronous mains reference input
package cpu_regs_pkg;
    localparam int WORD_W = 20;
    localparam int PADDR_W = 14;
    localparam int CHAR_W = 7;
    localparam int IRQ_N = 12;
    localparam int AVM_AW = 4;
    // instruction field positions (bit 0 is the most significant bit)
    localparam int OP_HI = 19;
    localparam int OP_LO = 15;
    localparam int MOD_HI = 14;
    localparam int MOD_LO = 13;
    localparam int ADDR_HI = 12;
    localparam int ADDR_LO = 0;
    // storage locations used by the interrupt entry
    localparam logic [PADDR_W-1:0] SAVE_PADDR_LOC = 14'h0006;
    localparam logic [PADDR_W-1:0] SAVE_ACC_LOC = 14'h0007;
    localparam logic [PADDR_W-1:0] VECTOR_BASE = 14'h0007;
    // register word offsets (byte address = 4 * index)
    localparam logic [AVM_AW-1:0] REG_ACC = 4'h0;
    localparam logic [AVM_AW-1:0] REG_EXT = 4'h1;
    localparam logic [AVM_AW-1:0] REG_OPBUF = 4'h2;
    localparam logic [AVM_AW-1:0] REG_INSTR = 4'h3;
    localparam logic [AVM_AW-1:0] REG_PADDR = 4'h4;
    localparam logic [AVM_AW-1:0] REG_IRQ = 4'h5;
    localparam logic [AVM_AW-1:0] REG_CHAR1 = 4'h6;
    localparam logic [AVM_AW-1:0] REG_CHAR2 = 4'h7;
    localparam logic [AVM_AW-1:0] REG_CTRL = 4'h8;
    localparam logic [AVM_AW-1:0] REG_TOD = 4'h9;
    localparam logic [AVM_AW-1:0] REG_FLAGS = 4'ha;
    localparam logic [AVM_AW-1:0] REG_CMD = 4'hb;
    localparam logic [AVM_AW-1:0] REG_IRQSET = 4'hc;
    localparam logic [AVM_AW-1:0] REG_TODSET = 4'hd;
    // control register fields
    localparam int CTRL_GRP_LO = 0;
    localparam int CTRL_PERMIT = 2;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
    localparam int MAINS_HZ = 60;
    typedef enum logic [3:0] {
        CMD_NOP, CMD_ADD, CMD_SUB, CMD_MUL, CMD_DIV, CMD_LOAD_ACC, CMD_ACC_TO_EXT,
        CMD_SHIFT_L, CMD_SHIFT_R, CMD_TOD_TO_ACC, CMD_CONSOLE_TO_ACC, CMD_STEP,
        CMD_JUMP_ADDR, CMD_FETCH_INSTR, CMD_LOAD_OPBUF
    } cmd_t;
endpackage

/* hw/cpu_registers.sv */
// processor register complement: arithmetic registers, control registers,
// priority interrupt, character buffers and time-of-day clock
// assumes an avalon-mm master and a one-cycle-per-pulse mains reference
//////////////////////////////////////////////////////////////////////////////
module cpu_registers #(
    parameter int PADDR_BITS = cpu_regs_pkg::PADDR_W,
    parameter int MAINS_CYCLES_PER_SEC = cpu_regs_pkg::MAINS_HZ
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [cpu_regs_pkg::AVM_AW-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [cpu_regs_pkg::WORD_W-1:0] storage_word,
    input wire logic [cpu_regs_pkg::WORD_W-1:0] modifier_word,
    input wire logic mains_tick,
    input wire logic [cpu_regs_pkg::WORD_W-1:0] console_switches,
    input wire logic [cpu_regs_pkg::IRQ_N-1:0] irq_sources,
    output logic [cpu_regs_pkg::WORD_W-1:0] display_acc,
    output logic [cpu_regs_pkg::WORD_W-1:0] display_instr,
    output logic [cpu_regs_pkg::PADDR_W-1:0] display_paddr,
    output logic int_taken,
    output logic [cpu_regs_pkg::PADDR_W-1:0] int_save_paddr_loc,
    output logic [cpu_regs_pkg::PADDR_W-1:0] int_save_acc_loc,
    output logic [cpu_regs_pkg::WORD_W-1:0] int_save_acc,
    output logic [cpu_regs_pkg::PADDR_W-1:0] int_save_paddr,
    output logic [cpu_regs_pkg::PADDR_W-1:0] modifier_save_loc,
    output logic [cpu_regs_pkg::PADDR_W-1:0] modifier_save_value,
    output logic modifier_save_strobe
);
    import cpu_regs_pkg::*;

    //////////////////////////////////////////////////////////////////////////
    // registers
    logic [WORD_W-1:0] acc_r, ext_r, opbuf_r, instr_r;
    logic [PADDR_W-1:0] paddr_r;
    logic [CHAR_W-1:0] char1_r, char2_r;
    logic [IRQ_N-1:0] irq_r;
    logic [1:0] grp_en_r;
    logic permit_r;
    logic [3:0] tod_h1_r, tod_h0_r, tod_m1_r, tod_m0_r, tod_s1_r, tod_s0_r;
    logic [7:0] mains_cnt_r;
    logic wait_done_r;
    logic int_taken_r;
    logic [PADDR_W-1:0] int_save_paddr_r;
    logic [WORD_W-1:0] int_save_acc_r;
    logic mod_strobe_r;
    logic [PADDR_W-1:0] mod_loc_r, mod_val_r;
    logic [WORD_W-1:0] acc_nxt, ext_nxt;

    function automatic logic [3:0] bcd_inc(input logic [3:0] d, input logic [3:0] lim);
        bcd_inc = (d == lim) ? 4'h0 : d + 4'h1;
    endfunction

    //////////////////////////////////////////////////////////////////////////
    // bus decode; one wait state so every access answers at the second edge
    wire access = avs_read | avs_write;
    wire done = access & wait_done_r;
    wire wr = avs_write & done;
    wire [3:0] cmd_code = avs_writedata[3:0];
    wire do_cmd = wr & (avs_address == REG_CMD);
    assign avs_waitrequest = access & ~wait_done_r;

    // instruction fields, bit 0 being the msb
    wire [4:0] f_op = instr_r[OP_HI:OP_LO];
    wire [1:0] f_mod = instr_r[MOD_HI:MOD_LO];
    wire [12:0] f_addr = instr_r[ADDR_HI:ADDR_LO];
    // modifier word bits 7..19 added when selector nonzero; one extra word time
    wire [12:0] mod_addr = f_addr + modifier_word[ADDR_HI:ADDR_LO];

    // accumulator
    wire acc_neg = acc_r[WORD_W-1];
    wire acc_zero = (acc_r[WORD_W-2:0] == '0);
    wire acc_pos = ~acc_neg & ~acc_zero;
    wire acc_odd = acc_r[0];
    wire [4:0] flags = {~acc_odd, acc_odd, acc_zero, acc_neg, acc_pos};

    // sign-magnitude double word: sign of acc, 19+19 magnitude bits
    wire [37:0] dbl_mag = {acc_r[18:0], ext_r[18:0]};
    wire [18:0] op_mag = opbuf_r[18:0];
    wire op_sign = opbuf_r[19];

    // add/sub with operand buffer as second operand
    wire [19:0] acc_sv = acc_neg ? -{1'b0, acc_r[18:0]} : {1'b0, acc_r[18:0]};
    wire [19:0] op_sv = op_sign ? -{1'b0, op_mag} : {1'b0, op_mag};
    wire [19:0] sum_sv = acc_sv + op_sv;
    wire [19:0] dif_sv = acc_sv - op_sv;
    wire [19:0] sum_sm = {sum_sv[19], sum_sv[19] ? 19'(-sum_sv) : sum_sv[18:0]};
    wire [19:0] dif_sm = {dif_sv[19], dif_sv[19] ? 19'(-dif_sv) : dif_sv[18:0]};

    // product magnitude split across acc and ext
    wire [37:0] prod = {19'h0, acc_r[18:0]} * {19'h0, op_mag};
    wire res_sign = acc_neg ^ op_sign;

    // divide: dividend from acc:ext, zero divisor leaves registers alone
    wire div_ok = (op_mag != '0);
    wire [37:0] quo = div_ok ? dbl_mag / {19'h0, op_mag} : 38'h0;
    wire [37:0] rem = div_ok ? dbl_mag % {19'h0, op_mag} : 38'h0;

    // chained shift path: char2, char1, acc, ext
    wire [53:0] chain = {char2_r, char1_r, acc_r, ext_r};
    wire [53:0] chain_l = {chain[52:0], 1'b0};
    wire [53:0] chain_r = {1'b0, chain[53:1]};
    wire [53:0] chain_sh = (cmd_code == CMD_SHIFT_L) ? chain_l : chain_r;
    wire [23:0] tod_word = {tod_h1_r, tod_h0_r, tod_m1_r, tod_m0_r, tod_s1_r, tod_s0_r};
    // tens digits need only 2, 3 and 3 bits, so six digits fit a word
    wire [WORD_W-1:0] tod_acc = {tod_h1_r[1:0], tod_h0_r, tod_m1_r[2:0], tod_m0_r, tod_s1_r[2:0], tod_s0_r};


    // group enable mask, 00 none, 01 group one, 10 one+two, 11 all
    wire [IRQ_N-1:0] grp_mask = {{4{grp_en_r == 2'b11}}, {4{grp_en_r[1]}}, {4{grp_en_r != 2'b00}}};
    wire [IRQ_N-1:0] irq_live = irq_r & grp_mask;
    // lowest-numbered level wins
    wire [IRQ_N-1:0] irq_win = irq_live & (~irq_live + 12'h001);

    logic [3:0] irq_level;
    always_comb begin
        irq_level = 4'h0;
        for (int i = IRQ_N - 1; i >= 0; i--) begin
            if (irq_win[i]) begin
                irq_level = 4'(i + 1);
            end
        end
    end
    // interrupt taken at instruction boundary only when permitted
    wire step = do_cmd & (cmd_code == CMD_STEP);
    wire take_int = step & permit_r & (irq_live != '0);

    //////////////////////////////////////////////////////////////////////////
    // accumulator / extension next values
    always_comb begin
        acc_nxt = acc_r;
        ext_nxt = ext_r;
        if (do_cmd) begin
            case (cmd_code)
                CMD_ADD: acc_nxt = sum_sm;
                CMD_SUB: acc_nxt = dif_sm;
                CMD_MUL: begin
                    acc_nxt = {res_sign, prod[37:19]};
                    ext_nxt = {res_sign, prod[18:0]};
                end
                CMD_DIV: begin
                    if (div_ok) begin
                        acc_nxt = {res_sign, quo[18:0]};
                        ext_nxt = {acc_neg, rem[18:0]};
                    end
                end
                CMD_LOAD_ACC: acc_nxt = opbuf_r;
                CMD_ACC_TO_EXT: ext_nxt = acc_r;
                CMD_SHIFT_L, CMD_SHIFT_R: begin
                    acc_nxt = chain_sh[39:20];
                    ext_nxt = chain_sh[19:0];
                end
                CMD_TOD_TO_ACC: acc_nxt = tod_acc;
                CMD_CONSOLE_TO_ACC: acc_nxt = console_switches;
                default: ;
            endcase
        end
        if (wr && avs_address == REG_ACC) begin
            acc_nxt = avs_writedata[WORD_W-1:0];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            acc_r <= '0;
            ext_r <= '0;
        end else begin
            acc_r <= acc_nxt;
            ext_r <= ext_nxt;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // operand buffer and instruction path
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            opbuf_r <= '0;
            instr_r <= '0;
        end else begin
            if (do_cmd && cmd_code == CMD_LOAD_OPBUF) begin
                opbuf_r <= storage_word;
            end
            if (do_cmd && cmd_code == CMD_FETCH_INSTR) begin
                instr_r <= opbuf_r;
            end else if (wr && avs_address == REG_INSTR && f_mod != 2'b00) begin
                instr_r <= {instr_r[19:13], mod_addr};
            end
        end
    end

    // program address
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            paddr_r <= '0;
        end else if (take_int) begin
            paddr_r <= VECTOR_BASE + 14'(irq_level);
        end else if (step) begin
            paddr_r <= paddr_r + 14'h0001;
        end else if (do_cmd && cmd_code == CMD_JUMP_ADDR) begin
            paddr_r <= 14'(f_addr);
        end else if (wr && avs_address == REG_PADDR) begin
            paddr_r <= avs_writedata[PADDR_W-1:0];
        end
    end

    // modifier-slot store of program address
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            mod_strobe_r <= 1'b0;
            mod_loc_r <= '0;
            mod_val_r <= '0;
        end else begin
            // saves the address held before this same write lands
            mod_strobe_r <= wr && avs_address == REG_PADDR && avs_writedata[31];
            if (wr && avs_address == REG_PADDR && avs_writedata[31]) begin
                mod_loc_r <= 14'(avs_writedata[17:16]);
                mod_val_r <= paddr_r;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // interrupt requests, control and entry
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            irq_r <= '0;
            grp_en_r <= CTRL_RESET[CTRL_GRP_LO+:2];
            permit_r <= CTRL_RESET[CTRL_PERMIT];
            int_taken_r <= 1'b0;
            int_save_paddr_r <= '0;
            int_save_acc_r <= '0;
        end else begin
            // a source held high re-arms its level right after service
            // serviced level cleared; new requests set and win
            irq_r <= (irq_r & ~(take_int ? irq_win : 12'h000)) | irq_sources
                | ((wr && avs_address == REG_IRQSET) ? avs_writedata[IRQ_N-1:0] : 12'h000);
            if (wr && avs_address == REG_CTRL && avs_byteenable[0]) begin
                grp_en_r <= avs_writedata[CTRL_GRP_LO+:2];
                permit_r <= avs_writedata[CTRL_PERMIT];
            end
            int_taken_r <= take_int;
            if (take_int) begin
                int_save_paddr_r <= paddr_r;
                int_save_acc_r <= acc_r;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // character buffers: changed by shifting only, bus sees them read-only
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            char1_r <= '0;
            char2_r <= '0;
        end else if (do_cmd && (cmd_code == CMD_SHIFT_L || cmd_code == CMD_SHIFT_R)) begin
            char2_r <= chain_sh[53:47];
            char1_r <= chain_sh[46:40];
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // time of day, 24-hour bcd, ticked by mains reference
    wire sec_tick = mains_tick && (mains_cnt_r == 8'(MAINS_CYCLES_PER_SEC - 1));

    wire s0_wrap = tod_s0_r == 4'h9;
    wire s1_wrap = s0_wrap && tod_s1_r == 4'h5;
    wire m0_wrap = s1_wrap && tod_m0_r == 4'h9;
    wire m1_wrap = m0_wrap && tod_m1_r == 4'h5;
    wire day_wrap = m1_wrap && tod_h1_r == 4'h2 && tod_h0_r == 4'h3;
    wire [3:0] h0_lim = (tod_h1_r == 4'h2) ? 4'h3 : 4'h9;

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            mains_cnt_r <= '0;
            {tod_h1_r, tod_h0_r, tod_m1_r, tod_m0_r, tod_s1_r, tod_s0_r} <= '0;
        end else if (wr && avs_address == REG_TODSET) begin
            mains_cnt_r <= '0; // manual setting
            {tod_h1_r, tod_h0_r, tod_m1_r, tod_m0_r, tod_s1_r, tod_s0_r} <= avs_writedata[23:0];
        end else if (mains_tick) begin
            mains_cnt_r <= sec_tick ? 8'h00 : mains_cnt_r + 8'h01;
            if (sec_tick) begin
                tod_s0_r <= bcd_inc(tod_s0_r, 4'h9);
                if (s0_wrap) tod_s1_r <= bcd_inc(tod_s1_r, 4'h5);
                if (s1_wrap) tod_m0_r <= bcd_inc(tod_m0_r, 4'h9);
                if (m0_wrap) tod_m1_r <= bcd_inc(tod_m1_r, 4'h5);
                if (day_wrap) begin
                    tod_h1_r <= 4'h0;
                    tod_h0_r <= 4'h0;
                end else if (m1_wrap) begin
                    tod_h0_r <= bcd_inc(tod_h0_r, h0_lim);
                    if (tod_h0_r == 4'h9) tod_h1_r <= tod_h1_r + 4'h1;
                end
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // read mux and bus timing
    logic [31:0] rd_mux;
    always_comb begin
        case (avs_address)
            REG_ACC: rd_mux = {12'h000, acc_r};
            REG_EXT: rd_mux = {12'h000, ext_r};
            REG_OPBUF: rd_mux = {12'h000, opbuf_r};
            REG_INSTR: rd_mux = {12'h000, instr_r};
            REG_PADDR: rd_mux = {18'h0, paddr_r};
            REG_IRQ: rd_mux = {20'h0, irq_r};
            REG_CHAR1: rd_mux = {25'h0, char1_r};
            REG_CHAR2: rd_mux = {25'h0, char2_r};
            REG_CTRL: rd_mux = {29'h0, permit_r, grp_en_r};
            REG_TOD: rd_mux = {8'h00, tod_word};
            REG_FLAGS: rd_mux = {27'h0, flags};
            default: rd_mux = UNMAPPED_READ;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            wait_done_r <= 1'b0;
            avs_readdata <= '0;
        end else begin
            wait_done_r <= access & ~wait_done_r;
            // taken on the first edge so it stands at the completing one
            if (avs_read & ~wait_done_r) begin
                avs_readdata <= rd_mux;
            end
        end
    end

    // console displays driven straight from registers
    assign display_acc = acc_r;
    assign display_instr = instr_r;
    assign display_paddr = paddr_r;

    assign int_taken = int_taken_r;
    assign int_save_paddr_loc = SAVE_PADDR_LOC;
    assign int_save_acc_loc = SAVE_ACC_LOC;
    assign int_save_paddr = int_save_paddr_r;
    assign int_save_acc = int_save_acc_r;

    assign modifier_save_loc = mod_loc_r;
    assign modifier_save_value = mod_val_r;
    assign modifier_save_strobe = mod_strobe_r;
endmodule

/* verification/cpu_registers_asserts.sv */
// port checker for the processor register complement
// assumes one clock and a synchronous active-low reset; bound below
module cpu_registers_asserts (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [cpu_regs_pkg::AVM_AW-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic avs_waitrequest,
    input wire logic [cpu_regs_pkg::WORD_W-1:0] display_acc,
    input wire logic [cpu_regs_pkg::WORD_W-1:0] display_instr,
    input wire logic [cpu_regs_pkg::PADDR_W-1:0] display_paddr,
    input wire logic int_taken,
    input wire logic [cpu_regs_pkg::PADDR_W-1:0] int_save_paddr_loc,
    input wire logic [cpu_regs_pkg::PADDR_W-1:0] int_save_acc_loc,
    input wire logic [cpu_regs_pkg::WORD_W-1:0] int_save_acc,
    input wire logic [cpu_regs_pkg::PADDR_W-1:0] modifier_save_loc,
    input wire logic [cpu_regs_pkg::PADDR_W-1:0] modifier_save_value,
    input wire logic modifier_save_strobe
);
    import cpu_regs_pkg::*;
    logic wr_done;
    logic step_w;
    logic [1:0] grp_r;
    logic permit_r;
    assign wr_done = avs_write && !avs_waitrequest;
    assign step_w = wr_done && avs_address == REG_CMD && avs_writedata[3:0] == 4'hb;
    // shadow of the control register, so group and permit can be judged
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            grp_r <= 2'h0;
            permit_r <= 1'b0;
        end else if (wr_done && avs_address == REG_CTRL) begin
            grp_r <= avs_writedata[1:0];
            permit_r <= avs_writedata[CTRL_PERMIT];
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    //////////////////////////////////////////////////////////////////////////
    sequence access_open;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence stepped_recently;
        $past(step_w) || $past(step_w, 2);
    endsequence
    wait_one_a: assert property (access_open |=> !avs_waitrequest)
        else $error("access held more than one wait cycle");
    int_pulse_a: assert property (int_taken |=> !int_taken)
        else $error("interrupt pulse too long");
    int_locs_a: assert property (int_taken |-> int_save_paddr_loc == SAVE_PADDR_LOC &&
        int_save_acc_loc == SAVE_ACC_LOC) else $error("interrupt save locations wrong");
    int_vector_a: assert property (int_taken |-> display_paddr >= VECTOR_BASE + 1 &&
        display_paddr <= VECTOR_BASE + 12) else $error("interrupt vector out of range");
    int_acc_a: assert property (int_taken |-> int_save_acc == display_acc)
        else $error("saved accumulator differs");
    int_step_a: assert property (int_taken |-> stepped_recently)
        else $error("interrupt without a step");
    int_permit_a: assert property (int_taken |-> permit_r)
        else $error("interrupt while inhibited");
    int_group_a: assert property (int_taken |-> display_paddr <= VECTOR_BASE + 4 * grp_r)
        else $error("interrupt from disabled group");
    mod_save_a: assert property (modifier_save_strobe |-> modifier_save_loc inside {1, 2, 3} &&
        modifier_save_value == display_paddr) else $error("modifier save wrong");
    paddr_hold_a: assert property (!$stable(display_paddr) |-> $past(wr_done) || $past(wr_done, 2))
        else $error("program address moved on its own");
    acc_hold_a: assert property (!$stable(display_acc) |-> $past(wr_done))
        else $error("accumulator moved on its own");
endmodule
bind cpu_registers cpu_registers_asserts chk (.*);

/* verification/storage_model.sv */
// core storage word buffer model feeding the register complement
// assumes the bench preloads mem and picks the fetched word
module storage_model (
    input wire logic clk_sys,
    input wire logic [4:0] fetch_addr,
    input wire logic [cpu_regs_pkg::WORD_W-1:0] instr_word,
    input wire logic int_taken,
    input wire logic [cpu_regs_pkg::PADDR_W-1:0] int_save_paddr_loc,
    input wire logic [cpu_regs_pkg::PADDR_W-1:0] int_save_acc_loc,
    input wire logic [cpu_regs_pkg::WORD_W-1:0] int_save_acc,
    input wire logic [cpu_regs_pkg::PADDR_W-1:0] int_save_paddr,
    input wire logic [cpu_regs_pkg::PADDR_W-1:0] modifier_save_loc,
    input wire logic [cpu_regs_pkg::PADDR_W-1:0] modifier_save_value,
    input wire logic modifier_save_strobe,
    output logic [cpu_regs_pkg::WORD_W-1:0] storage_word,
    output logic [cpu_regs_pkg::WORD_W-1:0] modifier_word
);
    import cpu_regs_pkg::*;
    logic [WORD_W-1:0] mem [0:31];
    // small storage only: upper address bits are dropped
    assign storage_word = mem[fetch_addr];
    assign modifier_word = mem[{3'h0, instr_word[MOD_HI:MOD_LO]}];
    always @(posedge clk_sys) begin
        if (int_taken) begin
            mem[int_save_paddr_loc[4:0]] <= {6'h00, int_save_paddr};
            mem[int_save_acc_loc[4:0]] <= int_save_acc;
        end
        if (modifier_save_strobe) begin
            mem[modifier_save_loc[4:0]] <= {6'h00, modifier_save_value};
        end
    end
endmodule

/* verification/test_cpu_registers.sv */
// self-checking bench for the processor register complement
// assumes the storage model and the port checker beside the design
module test_cpu_registers;
    timeunit 1ns;
    timeprecision 1ps;
    import cpu_regs_pkg::*;
    logic clk_sys, reset_n, avs_read, avs_write, avs_waitrequest, mains_tick, int_taken, modifier_save_strobe;
    logic [3:0] avs_address, avs_byteenable;
    logic [31:0] avs_writedata, avs_readdata, seed, q, a, b, v;
    logic [WORD_W-1:0] storage_word, modifier_word, console_switches, display_acc, display_instr, int_save_acc;
    logic [IRQ_N-1:0] irq_sources;
    logic [PADDR_W-1:0] display_paddr, int_save_paddr_loc, int_save_acc_loc, int_save_paddr;
    logic [PADDR_W-1:0] modifier_save_loc, modifier_save_value;
    logic [4:0] fetch_addr;
    logic [2:0] ctl [8] = '{3'h4, 3'h5, 3'h5, 3'h2, 3'h6, 3'h3, 3'h7, 3'h7};
    logic [13:0] pa [8] = '{14'h101, 14'ha, 14'hb, 14'hc, 14'hd, 14'he, 14'h13, 14'h14};
    int n_fail, num_checks;
    // short mains count keeps the seconds rollover within a few ticks
    cpu_registers #(.MAINS_CYCLES_PER_SEC(2)) DUT (.*);
    storage_model SM (.*, .instr_word(display_instr));
    //////////////////////////////////////////////////////////////////////////
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    function logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function logic [31:0] sm_sub(input logic [31:0] x, input logic [31:0] y);
        return (x >= y) ? x - y : {12'h0, 1'b1, y[18:0] - x[18:0]};
    endfunction
    function logic [31:0] flg(input logic [31:0] x);
        return {27'h0, ~x[0], x[0], x[18:0] == 19'h0, x[19], ~x[19] & (x[18:0] != 19'h0)};
    endfunction
    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // request held until waitrequest is sampled low at a rising edge
    task bus(input logic wr, input logic [3:0] adr, input logic [31:0] d);
        avs_address <= adr;
        avs_writedata <= d;
        avs_read <= !wr;
        avs_write <= wr;
        do begin
            @(posedge clk_sys);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk_sys);
    endtask
    task run(input logic [31:0] acc, input logic [3:0] c, input logic [3:0] adr, input logic [31:0] exp);
        bus(1'b1, REG_ACC, acc);
        bus(1'b1, REG_CMD, {28'h0, c});
        bus(1'b0, adr, 32'h0);
        chk(q, exp);
    endtask
    task ld_op(input logic [31:0] w);
        SM.mem[16] = w[19:0];
        bus(1'b1, REG_CMD, 32'he);
    endtask
    task summarize();
        if (n_fail == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk_sys);
        n_fail++;
        summarize();
    end
    //////////////////////////////////////////////////////////////////////////
    initial begin
        seed = 32'h2f;
        n_fail = 0;
        num_checks = 0;
        reset_n = 1'b0;
        {avs_read, avs_write, mains_tick} = 3'h0;
        avs_address = 4'h0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hf;
        console_switches = 20'h0;
        irq_sources = 12'h0;
        fetch_addr = 5'h10;
        for (int i = 0; i < 32; i++) SM.mem[i] = 20'h0;
        repeat (6) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(posedge clk_sys);
        bus(1'b0, REG_ACC, 32'h0);
        chk(q, 32'h0);
        bus(1'b0, REG_CTRL, 32'h0);
        chk(q, CTRL_RESET);
        bus(1'b0, 4'he, 32'h0);
        chk(q, UNMAPPED_READ);
        bus(1'b1, REG_EXT, 32'h12345);
        bus(1'b0, REG_EXT, 32'h0);
        chk(q, 32'h0);
        bus(1'b1, REG_CHAR1, 32'h7f);
        bus(1'b0, REG_CHAR1, 32'h0);
        chk(q, 32'h0);
        repeat (4) begin
            a = xs() & 32'h3ffff;
            b = xs() & 32'h3ffff;
            ld_op(b);
            bus(1'b0, REG_OPBUF, 32'h0);
            chk(q, b);
            run(a, 4'h1, REG_ACC, a + b);
            run(a, 4'h2, REG_ACC, sm_sub(a, b));
            bus(1'b0, REG_FLAGS, 32'h0);
            chk(q, flg(sm_sub(a, b)));
            ld_op(b & 32'h1ff);
            run(a & 32'h3ff, 4'h3, REG_ACC, 32'h0);
            bus(1'b0, REG_EXT, 32'h0);
            chk(q, (a & 32'h3ff) * (b & 32'h1ff));
            run(a, 4'h6, REG_EXT, a);
            v = (b & 32'hfff) | 32'h1;
            ld_op(v);
            run(32'h0, 4'h4, REG_ACC, a / v);
            bus(1'b0, REG_EXT, 32'h0);
            chk(q, a % v);
        end
        v = xs();
        console_switches <= v[19:0];
        run(32'h0, 4'ha, REG_ACC, v & 32'hfffff);
        chk(display_acc, v & 32'hfffff);
        run(32'h80001, 4'h6, REG_EXT, 32'h80001);
        run(32'h80001, 4'h7, REG_CHAR1, 32'h1);
        bus(1'b0, REG_ACC, 32'h0);
        chk(q, 32'h3);
        bus(1'b1, REG_CMD, 32'h8);
        bus(1'b0, REG_EXT, 32'h0);
        chk(q, 32'h80001);
        v = xs() & 32'hfffff;
        v[14:13] = 2'b01;
        ld_op(v);
        run(32'h0, 4'h5, REG_ACC, v);
        bus(1'b1, REG_CMD, 32'hd);
        bus(1'b0, REG_INSTR, 32'h0);
        chk(q, v);
        chk(display_instr[OP_HI:OP_LO], v[19:15]);
        b = xs();
        SM.mem[1] = b[19:0];
        bus(1'b1, REG_INSTR, 32'h0);
        a = v;
        a[12:0] = v[12:0] + b[12:0];
        chk(display_instr, a);
        bus(1'b1, REG_PADDR, 32'h1fff);
        bus(1'b1, REG_CMD, 32'hb);
        chk(display_paddr, 32'h2000);
        bus(1'b1, REG_CMD, 32'hc);
        chk(display_paddr, a & 32'h1fff);
        bus(1'b1, REG_PADDR, 32'h8002_0000 | (a & 32'h1fff));
        @(posedge clk_sys);
        chk(SM.mem[2], a & 32'h1fff);
        bus(1'b1, REG_TODSET, 32'h235959);
        run(32'h0, 4'h9, REG_ACC, 32'h8ecd9);
        for (int k = 0; k < 2; k++) begin
            mains_tick <= 1'b1;
            @(posedge clk_sys);
            mains_tick <= 1'b0;
            repeat (3) @(posedge clk_sys);
            bus(1'b0, REG_TOD, 32'h0);
            chk(q, (k == 0) ? 32'h235959 : 32'h0);
        end
        bus(1'b1, REG_ACC, 32'h5a5a5);
        bus(1'b1, REG_PADDR, 32'h100);
        bus(1'b1, REG_IRQSET, 32'h024);
        irq_sources <= 12'h800;
        repeat (2) @(posedge clk_sys);
        irq_sources <= 12'h000;
        @(posedge clk_sys);
        // pending levels 3, 6 and 12 walked through control codes 2 to 7 (group and permit)
        for (int i = 0; i < 8; i++) begin
            bus(1'b1, REG_CTRL, {29'h0, ctl[i]});
            bus(1'b1, REG_CMD, 32'hb);
            chk(display_paddr, pa[i]);
            if (i == 1) begin
                bus(1'b0, REG_IRQ, 32'h0);
                chk(q, 32'h820);
            end
        end
        chk(SM.mem[6], 32'he);
        chk(SM.mem[7], 32'h5a5a5);
        bus(1'b0, REG_IRQ, 32'h0);
        chk(q, 32'h0);
        summarize();
    end
endmodule
